/* File: shared/sirq_params.svh */
// Constants for the serial interrupt flag and channel start block.
// Assumes it is included by the package and by the verification files by bare name.
`ifndef SIRQ_PARAMS_SVH
`define SIRQ_PARAMS_SVH

// Register byte offsets on the plain register port.
`define SIRQ_OFF_REQ 8'h00
`define SIRQ_OFF_MASK 8'h04
`define SIRQ_OFF_START 8'h08
`define SIRQ_OFF_STATUS 8'h0C
`define SIRQ_OFF_STOP 8'h10
`define SIRQ_OFF_RXEN 8'h14

// Field positions inside the request and mask registers.
`define SIRQ_BIT_ERR 7
`define SIRQ_BIT_RX 6
`define SIRQ_BIT_TX 5

// Field positions inside the status register.
`define SIRQ_STAT_EN_LSB 0
`define SIRQ_STAT_SETTLED_LSB 4

// Reset values.
`define SIRQ_MASK_RST 3'h7
`define SIRQ_FLAG_RST 3'h0
`define SIRQ_CHAN_RST 4'h0

// Cycles of the system clock that reception needs after its enable is set.
`define SIRQ_RX_SETTLE_CYC 3'h4

`endif

/* File: shared/sirq_pkg.sv */
// Types shared by the serial interrupt flag block.
// Assumes sirq_params.svh is on the include path.
`include "sirq_params.svh"

package sirq_pkg;

    // One bit per interrupt source: [2] error, [1] receive done, [0] transmit done.
    typedef logic [2:0] sirq_src_t;

    // One bit per serial channel.
    typedef logic [3:0] sirq_chan_t;

    // Register selected by an address.
    typedef enum logic [2:0] {
        SIRQ_SEL_NONE = 3'b000,
        SIRQ_SEL_REQ = 3'b001,
        SIRQ_SEL_MASK = 3'b010,
        SIRQ_SEL_START = 3'b011,
        SIRQ_SEL_STATUS = 3'b100,
        SIRQ_SEL_STOP = 3'b101,
        SIRQ_SEL_RXEN = 3'b110
    } sirq_sel_t;

    // Address decode, shared by the read and the write path.
    function automatic sirq_sel_t sirq_decode(input logic [7:0] addr);
        sirq_sel_t sel;
        sel = SIRQ_SEL_NONE;
        if (addr == `SIRQ_OFF_REQ) sel = SIRQ_SEL_REQ;
        if (addr == `SIRQ_OFF_MASK) sel = SIRQ_SEL_MASK;
        if (addr == `SIRQ_OFF_START) sel = SIRQ_SEL_START;
        if (addr == `SIRQ_OFF_STATUS) sel = SIRQ_SEL_STATUS;
        if (addr == `SIRQ_OFF_STOP) sel = SIRQ_SEL_STOP;
        if (addr == `SIRQ_OFF_RXEN) sel = SIRQ_SEL_RXEN;
        return sel;
    endfunction : sirq_decode

    // Packs the three source bits into their 8-bit register positions.
    function automatic logic [7:0] sirq_pack(input sirq_src_t src);
        logic [7:0] v;
        v = 8'h00;
        v[`SIRQ_BIT_ERR] = src[2];
        v[`SIRQ_BIT_RX] = src[1];
        v[`SIRQ_BIT_TX] = src[0];
        return v;
    endfunction : sirq_pack

    // Pulls the three source bits out of an 8-bit register value.
    function automatic sirq_src_t sirq_unpack(input logic [7:0] v);
        return {v[`SIRQ_BIT_ERR], v[`SIRQ_BIT_RX], v[`SIRQ_BIT_TX]};
    endfunction : sirq_unpack

endpackage : sirq_pkg

/* File: shared/sirq_flag_if.sv */
// Interface between the register front end and the request flag bank.
// Assumes one clock and one synchronised reset shared by both ends.
`timescale 1ns/1ns
`default_nettype none

interface sirq_flag_if;
    import sirq_pkg::*;

    sirq_src_t evt;       // Event pulses from the serial channels.
    logic wr_flag;        // Write strobe for the request flags.
    logic wr_mask;        // Write strobe for the mask bits.
    sirq_src_t wdata;     // Written source bits.
    sirq_src_t flags;     // Current request flags.
    sirq_src_t mask;      // Current mask bits.
    sirq_src_t pending;   // Flags that are not masked.

    modport front (output evt, output wr_flag, output wr_mask, output wdata,
                   input flags, input mask, input pending);
    modport bank (input evt, input wr_flag, input wr_mask, input wdata,
                  output flags, output mask, output pending);
endinterface : sirq_flag_if

`default_nettype wire

/* File: rtl/sirq_flags.sv */
// Request flag and mask bank for the three serial interrupt sources.
// Assumes writes and events arrive on the same clock as the bank.
`timescale 1ns/1ns
`default_nettype none

module sirq_flags
    import sirq_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    sirq_flag_if.bank fl
);

    sirq_src_t flag_q;  // Sticky request flags.
    sirq_src_t flag_d;  // Next request flags.
    sirq_src_t mask_q;  // Mask bits, one disables a source.
    sirq_src_t mask_d;  // Next mask bits.

    ////////////////////////////////////////////////////////////////////////
    // Next state. A written zero clears a flag, a written one leaves it.
    // The event term is ORed in last so that a set in the clearing cycle
    // is never lost.
    always_comb begin
        flag_d = flag_q;
        if (fl.wr_flag) begin
            flag_d = flag_q & fl.wdata;  // [RQ8]
        end
        flag_d = flag_d | fl.evt;  // [RQ1]
        mask_d = mask_q;
        if (fl.wr_mask) begin
            mask_d = fl.wdata;  // [RQ2]
        end
    end

    // Registers only.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_q <= `SIRQ_FLAG_RST;
            mask_q <= `SIRQ_MASK_RST;
        end else begin
            flag_q <= flag_d;
            mask_q <= mask_d;
        end
    end

    assign fl.flags = flag_q;
    assign fl.mask = mask_q;
    // A masked flag still stays set in the flag register but is left out of pending; it only stops
    // reaching the per-source and summary interrupt lines.
    assign fl.pending = flag_q & ~mask_q;  // [RQ2]

endmodule : sirq_flags

`default_nettype wire

/* File: rtl/sirq_top.sv */
// Serial interrupt request flags, masks and channel start trigger.
// Assumes a processor on the plain register port and UART channels on the
// same clock that deliver one-cycle event pulses.
//
// Notes on behaviour
// RQ1: Error, receive, transmit flags at bits 7,6,5.
// RQ2: Mask bit one disables its request, zero enables.
// RQ3: Software clears flags before unmasking and starting.
// RQ4: Start bit one sets enable, enters wait state.
// RQ5: Start bit zero leaves that channel untouched.
// RQ6: Four start bits at 3..0, upper bits zero.
// RQ7: Software waits four cycles after receive enable.
// RQ8: Set flag stays until software writes zero.
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ns
`default_nettype none

module sirq_top
    import sirq_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic rx_error_evt_i,
    input wire logic rx_done_evt_i,
    input wire logic tx_done_evt_i,
    output logic irq_o,
    output logic rx_error_interrupt_o,
    output logic rx_done_interrupt_o,
    output logic tx_done_interrupt_o,
    output logic [3:0] chan_enabled_status_o,
    output logic [3:0] chan_start_pulse_o,
    output logic [3:0] receive_enable_bit_o
);

    ////////////////////////////////////////////////////////////////////////
    // Reset release. The assertion is asynchronous, the release passes two
    // flip-flops so that no register sees it near a clock edge.
    // A reset pulse shorter than a clock period still clears every register.

    logic rst_meta_q;  // First stage, read only by the second.
    logic rst_n_q;     // Synchronised active-low reset used below.

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address decode and the flag bank.

    sirq_sel_t wsel;  // Register hit by a write.
    sirq_sel_t rsel;  // Register hit by a read.
    sirq_flag_if fl ();

    // A write selects a register only while its strobe is high; the read
    // select is gated later, inside the read mux.
    assign wsel = wr_i ? sirq_decode(addr_i) : SIRQ_SEL_NONE;
    assign rsel = sirq_decode(addr_i);

    // Events come from logic on this clock, so no synchroniser is needed.
    assign fl.evt = {rx_error_evt_i, rx_done_evt_i, tx_done_evt_i};  // [RQ1]
    assign fl.wr_flag = (wsel == SIRQ_SEL_REQ);
    assign fl.wr_mask = (wsel == SIRQ_SEL_MASK);
    assign fl.wdata = sirq_unpack(wdata_i[7:0]);

    // The bank holds the sticky request flags and the mask bits.
    sirq_flags u_flags (
        .clk_i (clk_i),
        .rst_n_i (rst_n_q),
        .fl (fl.bank)
    );

    ////////////////////////////////////////////////////////////////////////
    // Channel state: enable status, wait-state entry pulse, receive enable
    // and the settling counters that show when reception may be started.

    sirq_chan_t chan_en_q;       // Channel enabled status.
    sirq_chan_t chan_en_d;
    sirq_chan_t start_pulse_q;   // One-cycle pulse: channel enters wait state.
    sirq_chan_t start_pulse_d;
    sirq_chan_t rx_en_q;         // Receive enable per channel.
    sirq_chan_t rx_en_d;
    logic [2:0] settle_q [4];    // Cycles since receive enable was set.
    logic [2:0] settle_d [4];
    sirq_chan_t settled;         // Settling time has passed.
    sirq_chan_t start_bits;      // Trigger bits of a start write.
    sirq_chan_t stop_bits;       // Stop bits of a stop write.

    // Only the low four data bits are triggers; anything above is ignored.
    assign start_bits = (wsel == SIRQ_SEL_START) ? wdata_i[3:0] : `SIRQ_CHAN_RST;  // [RQ6]
    assign stop_bits = (wsel == SIRQ_SEL_STOP) ? wdata_i[3:0] : `SIRQ_CHAN_RST;

    // Next values for the channel group.
    always_comb begin
        // A zero trigger bit contributes nothing, so the OR leaves the
        // channel exactly as it was.
        chan_en_d = (chan_en_q & ~stop_bits) | start_bits;  // [RQ4] [RQ5]
        start_pulse_d = start_bits;  // [RQ4]
        rx_en_d = rx_en_q;
        if (wsel == SIRQ_SEL_RXEN) begin
            rx_en_d = wdata_i[3:0];
        end
        for (int i = 0; i < 4; i++) begin
            // The counter restarts whenever reception is off and then stops
            // at the settling figure, so it cannot wrap.
            if (!rx_en_q[i]) begin
                settle_d[i] = 3'h0;
            end else if (settle_q[i] < `SIRQ_RX_SETTLE_CYC) begin
                settle_d[i] = settle_q[i] + 3'h1;
            end else begin
                settle_d[i] = settle_q[i];
            end
        end
    end

    // Settling is only reported; a start before it is not refused, since
    // waiting is software's duty and the hardware cannot know the intent.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            settled[i] = (settle_q[i] >= `SIRQ_RX_SETTLE_CYC);  // [RQ7]
        end
    end

    // Registers only.
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            chan_en_q <= `SIRQ_CHAN_RST;
            start_pulse_q <= `SIRQ_CHAN_RST;
            rx_en_q <= `SIRQ_CHAN_RST;
            for (int i = 0; i < 4; i++) begin
                settle_q[i] <= 3'h0;
            end
        end else begin
            chan_en_q <= chan_en_d;
            start_pulse_q <= start_pulse_d;
            rx_en_q <= rx_en_d;
            for (int i = 0; i < 4; i++) begin
                settle_q[i] <= settle_d[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data and interrupt outputs, all registered.

    logic [31:0] rdata_q;  // Read data, valid the cycle after the strobe.
    logic [31:0] rdata_d;
    sirq_src_t irq_src_q;  // Unmasked pending requests per source.
    sirq_src_t irq_src_d;  // Next per-source requests.
    logic irq_q;           // Any unmasked request.
    logic irq_d;           // Next summary request.

    // Read mux; an unmapped address or no strobe reads as zero.
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (rd_i) begin
            unique case (rsel)
                SIRQ_SEL_REQ: begin
                    rdata_d[7:0] = sirq_pack(fl.flags);  // [RQ1]
                end
                SIRQ_SEL_MASK: begin
                    rdata_d[7:0] = sirq_pack(fl.mask);
                end
                SIRQ_SEL_STATUS: begin
                    rdata_d[`SIRQ_STAT_EN_LSB +: 4] = chan_en_q;
                    rdata_d[`SIRQ_STAT_SETTLED_LSB +: 4] = settled;
                end
                SIRQ_SEL_RXEN: begin
                    rdata_d[3:0] = rx_en_q;
                end
                // The start and stop triggers are write-only.
                SIRQ_SEL_START, SIRQ_SEL_STOP, SIRQ_SEL_NONE: begin
                    rdata_d = 32'h0000_0000;  // [RQ6]
                end
            endcase
        end
    end

    // Next interrupt values. A masked flag stays in the bank but is kept
    // off both the per-source lines and the summary line.
    always_comb begin
        irq_src_d = fl.pending;  // [RQ2]
        irq_d = |fl.pending;  // [RQ2]
    end

    // Registers only. The interrupt lags the flag by one cycle, traded for
    // an output straight from a flip-flop.
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= 32'h0000_0000;
            irq_src_q <= `SIRQ_FLAG_RST;
            irq_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            irq_src_q <= irq_src_d;
            irq_q <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, each taken straight from a register so that nothing outside
    // sees a combinational glitch.

    assign rdata_o = rdata_q;
    assign irq_o = irq_q;
    assign rx_error_interrupt_o = irq_src_q[2];
    assign rx_done_interrupt_o = irq_src_q[1];
    assign tx_done_interrupt_o = irq_src_q[0];
    assign chan_enabled_status_o = chan_en_q;
    assign chan_start_pulse_o = start_pulse_q;
    assign receive_enable_bit_o = rx_en_q;

endmodule : sirq_top

`default_nettype wire

/* File: verification/sirq_top_props.sv */
// Checker for the serial interrupt flags and channel start block.
// Assumes it is bound to sirq_top and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
`include "sirq_params.svh"

module sirq_top_props (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic rx_error_evt_i,
    input wire logic rx_done_evt_i,
    input wire logic irq_o,
    input wire logic rx_error_interrupt_o,
    input wire logic rx_done_interrupt_o,
    input wire logic tx_done_interrupt_o,
    input wire logic [3:0] chan_enabled_status_o,
    input wire logic [3:0] chan_start_pulse_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    ////////////////////////////////////////////////////////////////////////
    // Decoded writes, kept as plain wires so that $past can look back at them.
    logic start_w;
    logic mask_w;
    logic err_clr_w;
    assign start_w = wr_i && addr_i == `SIRQ_OFF_START;
    assign mask_w = wr_i && addr_i == `SIRQ_OFF_MASK;
    assign err_clr_w = wr_i && addr_i == `SIRQ_OFF_REQ && !wdata_i[`SIRQ_BIT_ERR];

    // A start write, and an error clear that no new error event races.
    sequence s_start_wr;
        start_w;
    endsequence
    sequence s_err_clr;
        err_clr_w && !rx_error_evt_i;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    AST_START_PULSE: assert property (s_start_wr |=> chan_start_pulse_o == $past(wdata_i[3:0]))
        else $error("start pulse does not follow written trigger bits");
    AST_PULSE_CAUSE: assert property (chan_start_pulse_o != 4'h0 |-> $past(start_w))
        else $error("start pulse without a start write");
    AST_START_SET: assert property (s_start_wr |=>
        (chan_enabled_status_o & $past(wdata_i[3:0])) == $past(wdata_i[3:0]))
        else $error("triggered channel not enabled");
    AST_START_KEEP: assert property (s_start_wr |=>
        (chan_enabled_status_o | $past(wdata_i[3:0])) == ($past(chan_enabled_status_o) | $past(wdata_i[3:0])))
        else $error("untriggered channel changed state");
    AST_START_RD: assert property (rd_i && addr_i == `SIRQ_OFF_START |=> rdata_o == 32'h0000_0000)
        else $error("start register does not read as zero");
    AST_REQ_RD: assert property (rd_i && addr_i == `SIRQ_OFF_REQ |=>
        rdata_o[31:8] == 24'h00_0000 && rdata_o[4:0] == 5'h00)
        else $error("request register shows bits outside 7 to 5");
    AST_ERR_CLEAR: assert property (s_err_clr |-> ##2 !rx_error_interrupt_o)
        else $error("error request survives a clearing write");
    AST_ERR_HOLD: assert property ($fell(rx_error_interrupt_o) |-> $past(err_clr_w, 2) || $past(mask_w, 2))
        else $error("error request dropped on its own");
    AST_RX_RISE: assert property ($rose(rx_done_interrupt_o) |-> $past(rx_done_evt_i, 2) || $past(mask_w, 2))
        else $error("receive request appeared without cause");
    AST_IRQ_ANY: assert property (irq_o == (rx_error_interrupt_o | rx_done_interrupt_o | tx_done_interrupt_o))
        else $error("summary interrupt differs from the sources");
endmodule : sirq_top_props

bind sirq_top sirq_top_props props_u (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_error_evt_i(rx_error_evt_i), .rx_done_evt_i(rx_done_evt_i),
    .irq_o(irq_o), .rx_error_interrupt_o(rx_error_interrupt_o), .rx_done_interrupt_o(rx_done_interrupt_o),
    .tx_done_interrupt_o(tx_done_interrupt_o), .chan_enabled_status_o(chan_enabled_status_o),
    .chan_start_pulse_o(chan_start_pulse_o));

`default_nettype wire

/* File: verification/sirq_tb.sv */
// Self-checking bench for the serial interrupt flags and channel start block.
// Assumes sirq_top, its package and the bound checker are compiled before it.
`timescale 1ns/1ns
`default_nettype none
`include "sirq_params.svh"

module testbench;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0000_0000;
    logic [2:0] evt = 3'h0; // Error, receive and transmit event pulses.
    logic [31:0] rdata_o;
    logic irq_o, err_o, rx_o, tx_o;
    logic [3:0] en_o, pulse_o, rxen_o;
    int err_count = 0;
    int total_checks = 0;

    sirq_top dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .rx_error_evt_i(evt[2]), .rx_done_evt_i(evt[1]), .tx_done_evt_i(evt[0]), .irq_o(irq_o),
        .rx_error_interrupt_o(err_o), .rx_done_interrupt_o(rx_o), .tx_done_interrupt_o(tx_o),
        .chan_enabled_status_o(en_o), .chan_start_pulse_o(pulse_o), .receive_enable_bit_o(rxen_o));

    // A 250 MHz clock.
    initial begin
        forever #2 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // Counts a comparison and reports a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Prints the verdict and ends the run.
    task automatic summarize();
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    // One-cycle write; returns 1 ns after the taking edge, when effects show.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask : wr

    // One-cycle read; the data stand only in the following cycle.
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask : rd_chk

    // One-cycle event pulse on the selected sources.
    task automatic pulse_evt(input logic [2:0] e);
        @(posedge clk_i);
        evt <= e;
        @(posedge clk_i);
        evt <= 3'h0;
        #1;
    endtask : pulse_evt

    task automatic step();
        @(posedge clk_i);
        #1;
    endtask : step

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd_chk(`SIRQ_OFF_REQ, 32'h0000_0000);
        rd_chk(`SIRQ_OFF_MASK, 32'h0000_00E0);
        rd_chk(8'h40, 32'h0000_0000);
        chk({28'h000_0000, en_o}, 32'h0000_0000);
    endtask : t_reset

    // Masked events latch; unmasking raises each source; writing zero clears it.
    task automatic t_flags();
        logic [31:0] m;
        for (int k = 0; k < 3; k++) begin
            pulse_evt(3'h1 << k);
            step();
            chk({31'h0, irq_o}, 32'h0000_0000);
            rd_chk(`SIRQ_OFF_REQ, (32'h0000_0040 << k) - 32'h0000_0020);
        end
        wr(`SIRQ_OFF_REQ, 32'h0000_00E0);
        rd_chk(`SIRQ_OFF_REQ, 32'h0000_00E0);
        for (int k = 0; k < 3; k++) begin
            m = 32'h0000_00E0 & ~(32'h0000_0020 << k);
            wr(`SIRQ_OFF_MASK, m);
            step();
            chk({29'h0, err_o, rx_o, tx_o}, 32'h0000_0001 << k);
            chk({31'h0, irq_o}, 32'h0000_0001);
            wr(`SIRQ_OFF_REQ, m);
            step();
            chk({31'h0, irq_o}, 32'h0000_0000);
            wr(`SIRQ_OFF_MASK, 32'h0000_00E0);
        end
        rd_chk(`SIRQ_OFF_REQ, 32'h0000_0000);
        wr(`SIRQ_OFF_MASK, 32'h0000_0000);
        pulse_evt(3'h2);
        step();
        chk({30'h0, rx_o, irq_o}, 32'h0000_0003);
        wr(`SIRQ_OFF_REQ, 32'h0000_00A0);
        step();
        chk({30'h0, rx_o, irq_o}, 32'h0000_0000);
    endtask : t_flags

    // Receive enable, settle wait, then start and stop of channels.
    task automatic t_start();
        wr(`SIRQ_OFF_REQ, 32'h0000_0000);
        wr(`SIRQ_OFF_MASK, 32'h0000_0000);
        step();
        chk({29'h0, err_o, rx_o, tx_o}, 32'h0000_0000);
        wr(`SIRQ_OFF_RXEN, 32'h0000_0001);
        rd_chk(`SIRQ_OFF_STATUS, 32'h0000_0000);
        repeat (4) step();
        chk({28'h0, rxen_o}, 32'h0000_0001);
        rd_chk(`SIRQ_OFF_RXEN, 32'h0000_0001);
        wr(`SIRQ_OFF_START, 32'hFFFF_FFF5);
        chk({24'h0, pulse_o, en_o}, 32'h0000_0055);
        step();
        chk({28'h0, pulse_o}, 32'h0000_0000);
        wr(`SIRQ_OFF_START, 32'h0000_0002);
        chk({28'h0, en_o}, 32'h0000_0007);
        wr(`SIRQ_OFF_START, 32'h0000_0000);
        chk({24'h0, pulse_o, en_o}, 32'h0000_0007);
        rd_chk(`SIRQ_OFF_START, 32'h0000_0000);
        rd_chk(`SIRQ_OFF_STOP, 32'h0000_0000);
        rd_chk(`SIRQ_OFF_STATUS, 32'h0000_0017);
        wr(`SIRQ_OFF_STOP, 32'h0000_000F);
        chk({28'h0, en_o}, 32'h0000_0000);
    endtask : t_start

    // A reset in mid-run drops the summary interrupt, error interrupt and channel enable outputs and restores the masks.
    task automatic t_mid_reset();
        wr(`SIRQ_OFF_START, 32'h0000_0008);
        pulse_evt(3'h4);
        step();
        chk({29'h0, irq_o, err_o, |en_o}, 32'h0000_0007);
        @(posedge clk_i);
        nrst_i <= 1'b0;
        #1;
        chk({29'h0, irq_o, err_o, |en_o}, 32'h0000_0000);
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rd_chk(`SIRQ_OFF_MASK, 32'h0000_00E0);
        rd_chk(`SIRQ_OFF_REQ, 32'h0000_0000);
    endtask : t_mid_reset

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        t_reset();
        t_flags();
        t_start();
        t_mid_reset();
        summarize();
    end

    // The tests take well under a thousand cycles; this cuts a hang short.
    initial begin
        #20000;
        err_count++;
        summarize();
    end
endmodule : testbench

`default_nettype wire
